// ===== hdl/bridge_secondary_config_regs.sv
// Secondary-side type 1 header fields with APB access and window decode
//
// Decided for this implementation: the APB register port.
`timescale 1ns/1ps
`include "bridge_sec_cfg.svh"
// Behaviour
// R01 - Subordinate bus byte 23:16, writable, resets 00h
// R02 - Latency timer 31:24 reads 00h, writes ignored
// R03 - I/O indicators 3:0 and 11:8 read 01h
// R04 - I/O base 7:4 gives bits 15:12, low zero
// R05 - I/O limit 15:12 gives bits 15:12, low FFFh
// R06 - I/O address bits 31:16 from upper registers
// R07 - I/O window decides I/O forwarding
// R08 - Status bits 20:16, 21, 22, 23, 26:25 zero
// R09 - Bit 24 set on secondary parity error
// R10 - Bit 24 never set without parity response
// R11 - Bit 27 set on completer abort sent
// R12 - Bit 28 set on completer abort received
// R13 - Bit 29 set on unsupported request received
// R14 - Bit 30 set on error message, enable set
// R15 - Bit 31 set on poisoned TLP received
// R16 - Memory base 15:4 gives 31:20, 3:0 zero
// R17 - Memory window decides memory forwarding
// R18 - Memory limit 31:20, low bits FFFFFh
// R19 - Write one clears flag, zero leaves it; here only bits 24, 30, 31 clear, bits 27-29 hold until reset
// R20 - Window bounds are both inclusive
module bridge_secondary_config_regs
  import bridge_sec_pkg::*;
(
  input  wire logic        I_REF_CLK,
  input  wire logic        I_RESET_N,
  // APB slave
  input  wire logic        I_PSEL,
  input  wire logic        I_PENABLE,
  input  wire logic        I_PWRITE,
  input  wire logic [11:0] I_PADDR,
  input  wire logic [31:0] I_PWDATA,
  input  wire logic [3:0]  I_PSTRB,
  output logic      [31:0] O_PRDATA,
  output logic             O_PREADY,
  output logic             O_PSLVERR,
  // Secondary-side error events, one-cycle pulses from core logic
  input  wire logic        I_PARITY_EVT,
  input  wire logic        I_CA_SENT_EVT,
  input  wire logic        I_CA_RCVD_EVT,
  input  wire logic        I_UR_RCVD_EVT,
  input  wire logic        I_ERR_MSG_EVT,
  input  wire logic        I_POISON_EVT,
  // Upper halves of the I/O window, from their own registers
  input  wire logic [15:0] I_IO_BASE_UPPER,
  input  wire logic [15:0] I_IO_LIMIT_UPPER,
  // Transaction offered for forwarding
  input  wire logic        I_TLP_VALID,
  input  wire logic        I_TLP_IS_IO,
  input  wire logic [31:0] I_TLP_ADDR,
  // Forwarding decision, one cycle after the offer
  output logic             O_FWD_VALID,
  output logic             O_FWD_IO_HIT,
  output logic             O_FWD_MEM_HIT,
  output logic [7:0]       O_SUB_BUS
);

  // Bundled inputs
  apb_req_t apb;        // APB request
  err_evt_t evt;        // Error events
  fwd_req_t tlp;        // Forwarding request

  assign apb = '{sel: I_PSEL, enable: I_PENABLE, write: I_PWRITE,
                 addr: I_PADDR, wdata: I_PWDATA, strb: I_PSTRB};
  assign evt = '{poison: I_POISON_EVT, err_msg: I_ERR_MSG_EVT,
                 ur_rcvd: I_UR_RCVD_EVT, ca_rcvd: I_CA_RCVD_EVT,
                 ca_sent: I_CA_SENT_EVT, parity: I_PARITY_EVT};
  assign tlp = '{valid: I_TLP_VALID, is_io: I_TLP_IS_IO,
                 addr: I_TLP_ADDR};

  // Map a word address to a register; low two bits ignored
  function automatic reg_sel_t decode(input logic [11:0] addr);
    reg_sel_t s;
    s = REG_NONE;
    case ({addr[11:2], 2'b00})
      `OFS_BUS_WORD:  s = REG_BUS;
      `OFS_IO_WORD:   s = REG_IO;
      `OFS_MEM_WORD:  s = REG_MEM;
      `OFS_CTRL_WORD: s = REG_CTRL;
      default:        s = REG_NONE;
    endcase
    return s;
  endfunction

  // Expand byte strobes to a bit mask
  function automatic logic [31:0] lane_mask(input logic [3:0] strb);
    logic [31:0] m;
    m = 32'h00000000;
    for (int b = 0; b < 4; b++)
    begin
      m[b*8 +: 8] = {8{strb[b]}};
    end
    return m;
  endfunction

  // Stored fields
  logic [7:0]  sub_bus_r;       // Highest downstream bus number
  logic [7:0]  sub_bus_nxt;
  logic [3:0]  io_base_r;       // I/O base address bits 15:12
  logic [3:0]  io_base_nxt;
  logic [3:0]  io_lim_r;        // I/O limit address bits 15:12
  logic [3:0]  io_lim_nxt;
  logic [11:0] mem_base_r;      // Memory base address bits 31:20
  logic [11:0] mem_base_nxt;
  logic [11:0] mem_lim_r;       // Memory limit address bits 31:20
  logic [11:0] mem_lim_nxt;
  logic [1:0]  ctrl_r;          // Parity response and error report enables
  logic [1:0]  ctrl_nxt;

  // APB answer registers
  logic [31:0] prdata_r;        // Read data, loaded in the setup cycle
  logic [31:0] prdata_nxt;
  logic        pready_r;        // Ready, high for the one access cycle
  logic        pready_nxt;
  logic        pslverr_r;       // Error for an unmapped address
  logic        pslverr_nxt;

  // Forwarding decision registers
  logic        fwd_valid_r;
  logic        fwd_valid_nxt;
  logic        io_hit_r;
  logic        io_hit_nxt;
  logic        mem_hit_r;
  logic        mem_hit_nxt;

  // Error flags and their controls
  logic [`ERR_FLAG_N-1:0] flags;     // Current flag values
  logic [`ERR_FLAG_N-1:0] flag_set;  // Hardware set requests
  logic [`ERR_FLAG_N-1:0] flag_clr;  // Software clear requests

  // Decode and strobe helpers
  reg_sel_t    sel;             // Register under the current address
  logic        setup;           // APB setup cycle
  logic        wr;              // Write completing at this edge
  logic [31:0] wmask;           // Written bit lanes

  // Register images as software reads them
  logic [31:0] word_bus;
  logic [31:0] word_io;
  logic [31:0] word_mem;
  logic [31:0] word_ctrl;
  logic [31:0] rd_word;         // Selected image

  // Full window bounds
  logic [31:0] io_base_addr;
  logic [31:0] io_lim_addr;
  logic [31:0] mem_base_addr;
  logic [31:0] mem_lim_addr;
  logic        io_match;        // Address inside the I/O window
  logic        mem_match;       // Address inside the memory window

  assign sel   = decode(apb.addr);
  assign setup = apb.sel & ~apb.enable;
  // Writes take effect only at the completing access edge
  assign wr    = apb.sel & apb.enable & pready_r & apb.write;
  assign wmask = lane_mask(apb.strb);

  // Bus word: primary and secondary bus bytes live elsewhere, read zero
  assign word_bus = {`SEC_LAT_CONST, sub_bus_r, 16'h0000};  // [R02]

  // I/O word with the secondary status in the upper half; the unused,
  // capability and timing bits are wired to zero here [R08]
  assign word_io = {flags[`FLG_POISON], flags[`FLG_SERR],
                    flags[`FLG_UR_RCVD], flags[`FLG_CA_RCVD],
                    flags[`FLG_CA_SENT], 2'b00, flags[`FLG_PAR],
                    8'h00, io_lim_r, `IO_ADDR_IND,
                    io_base_r, `IO_ADDR_IND};                  // [R03]

  // Memory word: low nibbles of both halves read zero [R16] [R18]
  assign word_mem = {mem_lim_r, 4'h0, mem_base_r, 4'h0};

  // Control word: enables for the gated flags
  assign word_ctrl = {30'h00000000, ctrl_r};

  // Select a read image
  always_comb
  begin
    case (sel)
      REG_BUS:  rd_word = word_bus;
      REG_IO:   rd_word = word_io;
      REG_MEM:  rd_word = word_mem;
      REG_CTRL: rd_word = word_ctrl;
      default:  rd_word = 32'h00000000;
    endcase
  end

  // Next values of the writable fields; only the writable part of a
  // merged word is picked up, so read-only bits never change
  always_comb
  begin
    logic [31:0] merged;
    merged       = (rd_word & ~wmask) | (apb.wdata & wmask);
    sub_bus_nxt  = sub_bus_r;
    io_base_nxt  = io_base_r;
    io_lim_nxt   = io_lim_r;
    mem_base_nxt = mem_base_r;
    mem_lim_nxt  = mem_lim_r;
    ctrl_nxt     = ctrl_r;
    if (wr)
    begin
      case (sel)
        REG_BUS:  sub_bus_nxt = merged[`SUB_BUS_LSB +: 8];   // [R01]
        REG_IO:
        begin
          io_base_nxt = merged[`IO_BASE_LSB +: 4];           // [R04]
          io_lim_nxt  = merged[`IO_LIM_LSB +: 4];            // [R05]
        end
        REG_MEM:
        begin
          mem_base_nxt = merged[`MEM_BASE_LSB +: 12];        // [R16]
          mem_lim_nxt  = merged[`MEM_LIM_LSB +: 12];         // [R18]
        end
        REG_CTRL: ctrl_nxt = merged[1:0];
        default:  sub_bus_nxt = sub_bus_r;                   // Unmapped: nothing stored
      endcase
    end
  end

  // Register the writable fields
  always_ff @(posedge I_REF_CLK or negedge I_RESET_N)
  begin
    if (!I_RESET_N)
    begin
      sub_bus_r  <= `SUB_BUS_RST;
      io_base_r  <= `IO_FIELD_RST;
      io_lim_r   <= `IO_FIELD_RST;
      mem_base_r <= `MEM_FIELD_RST;
      mem_lim_r  <= `MEM_FIELD_RST;
      ctrl_r     <= `CTRL_RST;
    end
    else
    begin
      sub_bus_r  <= sub_bus_nxt;
      io_base_r  <= io_base_nxt;
      io_lim_r   <= io_lim_nxt;
      mem_base_r <= mem_base_nxt;
      mem_lim_r  <= mem_lim_nxt;
      ctrl_r     <= ctrl_nxt;
    end
  end

  // Flag set and clear requests. Parity and error-message events are
  // dropped, not deferred, while their enable is off
  always_comb
  begin
    flag_set                = '0;
    flag_set[`FLG_PAR]      = evt.parity & ctrl_r[`CTRL_PAR_BIT];  // [R09] [R10]
    flag_set[`FLG_CA_SENT]  = evt.ca_sent;                         // [R11]
    flag_set[`FLG_CA_RCVD]  = evt.ca_rcvd;                         // [R12]
    flag_set[`FLG_UR_RCVD]  = evt.ur_rcvd;                         // [R13]
    flag_set[`FLG_SERR]     = evt.err_msg & ctrl_r[`CTRL_SERR_BIT]; // [R14]
    flag_set[`FLG_POISON]   = evt.poison;                          // [R15]
    flag_clr = '0;
    // A one in a written lane clears; zeros and unwritten lanes hold
    if (wr && (sel == REG_IO))
    begin
      flag_clr[`FLG_PAR]     = apb.wdata[24] & wmask[24];          // [R19]
      flag_clr[`FLG_CA_SENT] = apb.wdata[27] & wmask[27];
      flag_clr[`FLG_CA_RCVD] = apb.wdata[28] & wmask[28];
      flag_clr[`FLG_UR_RCVD] = apb.wdata[29] & wmask[29];
      flag_clr[`FLG_SERR]    = apb.wdata[30] & wmask[30];          // [R19]
      flag_clr[`FLG_POISON]  = apb.wdata[31] & wmask[31];          // [R19]
    end
  end

  // Sticky flags; the bank masks clears of read-only bits
  err_flag_bank u_flags
  (
    .i_clk   (I_REF_CLK),
    .i_rst_n (I_RESET_N),
    .i_set   (flag_set),
    .i_clr   (flag_clr),
    .o_flags (flags)
  );

  // APB answer: zero wait states. The image is captured in the setup
  // cycle, so an event arriving during the access shows on the next read
  always_comb
  begin
    pready_nxt  = setup;
    pslverr_nxt = setup & (sel == REG_NONE);
    prdata_nxt  = prdata_r;
    if (setup)
    begin
      prdata_nxt = rd_word;
    end
  end

  // Register the APB answer
  always_ff @(posedge I_REF_CLK or negedge I_RESET_N)
  begin
    if (!I_RESET_N)
    begin
      prdata_r  <= 32'h00000000;
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
    end
    else
    begin
      prdata_r  <= prdata_nxt;
      pready_r  <= pready_nxt;
      pslverr_r <= pslverr_nxt;
    end
  end

  // Window bounds: low bits fixed, I/O upper half from its own register
  assign io_base_addr  = {I_IO_BASE_UPPER, io_base_r, `IO_BASE_LOW};  // [R06] [R04]
  assign io_lim_addr   = {I_IO_LIMIT_UPPER, io_lim_r, `IO_LIM_LOW};   // [R06] [R05]
  assign mem_base_addr = {mem_base_r, `MEM_BASE_LOW};                 // [R16]
  assign mem_lim_addr  = {mem_lim_r, `MEM_LIM_LOW};                   // [R18]

  // I/O window comparator
  addr_window_match u_io_win
  (
    .i_addr  (tlp.addr),
    .i_base  (io_base_addr),
    .i_limit (io_lim_addr),
    .o_hit   (io_match)
  );

  // Memory window comparator
  addr_window_match u_mem_win
  (
    .i_addr  (tlp.addr),
    .i_base  (mem_base_addr),
    .i_limit (mem_lim_addr),
    .o_hit   (mem_match)
  );

  // Forwarding decision; a hit is only reported for the matching type
  always_comb
  begin
    fwd_valid_nxt = tlp.valid;
    io_hit_nxt    = tlp.valid & tlp.is_io & io_match;       // [R07] [R20]
    mem_hit_nxt   = tlp.valid & ~tlp.is_io & mem_match;     // [R17] [R20]
  end

  // Register the decision
  always_ff @(posedge I_REF_CLK or negedge I_RESET_N)
  begin
    if (!I_RESET_N)
    begin
      fwd_valid_r <= 1'b0;
      io_hit_r    <= 1'b0;
      mem_hit_r   <= 1'b0;
    end
    else
    begin
      fwd_valid_r <= fwd_valid_nxt;
      io_hit_r    <= io_hit_nxt;
      mem_hit_r   <= mem_hit_nxt;
    end
  end

  // Outputs, all straight from flip-flops
  assign O_PRDATA      = prdata_r;
  assign O_PREADY      = pready_r;
  assign O_PSLVERR     = pslverr_r;
  assign O_FWD_VALID   = fwd_valid_r;
  assign O_FWD_IO_HIT  = io_hit_r;
  assign O_FWD_MEM_HIT = mem_hit_r;
  assign O_SUB_BUS     = sub_bus_r;

endmodule

// ===== hdl/bridge_sec_cfg.svh
// Offsets, field positions, reset values and codes for the secondary config block
`ifndef BRIDGE_SEC_CFG_SVH
`define BRIDGE_SEC_CFG_SVH

// Register byte offsets on the 12-bit APB address
`define OFS_BUS_WORD      12'h018
`define OFS_IO_WORD       12'h01c
`define OFS_MEM_WORD      12'h020
`define OFS_CTRL_WORD     12'h040

// Field positions inside the 32-bit words
`define SUB_BUS_LSB       16
`define IO_BASE_LSB       4
`define IO_LIM_LSB        12
`define MEM_BASE_LSB      4
`define MEM_LIM_LSB       20
`define CTRL_PAR_BIT      0
`define CTRL_SERR_BIT     1

// Constant fields
`define IO_ADDR_IND       4'h1
`define SEC_LAT_CONST     8'h00
`define IO_BASE_LOW       12'h000
`define IO_LIM_LOW        12'hfff
`define MEM_BASE_LOW      20'h00000
`define MEM_LIM_LOW       20'hfffff

// Reset values
`define SUB_BUS_RST       8'h00
`define IO_FIELD_RST      4'h0
`define MEM_FIELD_RST     12'h000
`define CTRL_RST          2'h0
`define FLAGS_RST         6'h00

// Error flag vector: index to status bit 24,27,28,29,30,31
`define ERR_FLAG_N        6
`define FLG_PAR           0
`define FLG_CA_SENT       1
`define FLG_CA_RCVD       2
`define FLG_UR_RCVD       3
`define FLG_SERR          4
`define FLG_POISON        5
// Flags that software may clear by writing one
`define ERR_W1C_MASK      6'h31

`endif

// ===== hdl/bridge_sec_pkg.sv
// Types shared by the secondary config register block
package bridge_sec_pkg;

  // One APB request as seen by the slave
  typedef struct packed {
    logic        sel;
    logic        enable;
    logic        write;
    logic [11:0] addr;
    logic [31:0] wdata;
    logic [3:0]  strb;
  } apb_req_t;

  // Secondary-side error events, one-cycle pulses
  typedef struct packed {
    logic poison;
    logic err_msg;
    logic ur_rcvd;
    logic ca_rcvd;
    logic ca_sent;
    logic parity;
  } err_evt_t;

  // A transaction offered for the forwarding decision
  typedef struct packed {
    logic        valid;
    logic        is_io;
    logic [31:0] addr;
  } fwd_req_t;

  // Register selected by an address
  typedef enum logic [2:0] {
    REG_NONE = 3'h0,
    REG_BUS  = 3'h1,
    REG_IO   = 3'h2,
    REG_MEM  = 3'h3,
    REG_CTRL = 3'h4
  } reg_sel_t;

endpackage

// ===== hdl/addr_window_match.sv
// Inclusive address window comparator
`timescale 1ns/1ps
module addr_window_match
(
  input  wire logic [31:0] i_addr,
  input  wire logic [31:0] i_base,
  input  wire logic [31:0] i_limit,
  output logic             o_hit
);

  // Both bounds belong to the window; base above limit gives no hit [R20]
  always_comb
  begin
    o_hit = (i_addr >= i_base) && (i_addr <= i_limit);
  end

endmodule

// ===== hdl/err_flag_bank.sv
// Sticky error flags, some clearable by writing one
`timescale 1ns/1ps
`include "bridge_sec_cfg.svh"
module err_flag_bank
(
  input  wire logic                    i_clk,
  input  wire logic                    i_rst_n,
  input  wire logic [`ERR_FLAG_N-1:0]  i_set,
  input  wire logic [`ERR_FLAG_N-1:0]  i_clr,
  output logic      [`ERR_FLAG_N-1:0]  o_flags
);

  localparam logic [`ERR_FLAG_N-1:0] W1C = `ERR_W1C_MASK;

  logic [`ERR_FLAG_N-1:0] flags_r;    // Flag storage
  logic [`ERR_FLAG_N-1:0] flags_nxt;  // Next flag values

  // One identical slice per flag
  for (genvar g = 0; g < `ERR_FLAG_N; g++)
  begin : g_flag
    // Set wins over a clear in the same cycle so no event is lost;
    // read-only flags ignore the clear and hold until reset [R19]
    always_comb
    begin
      flags_nxt[g] = (flags_r[g] & ~(i_clr[g] & W1C[g])) | i_set[g];
    end
  end

  // Register the flags
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      flags_r <= `FLAGS_RST;
    else
      flags_r <= flags_nxt;
  end

  assign o_flags = flags_r;

endmodule

// ===== verif/bridge_sec_cfg_monitor.sv
// Port checker for the secondary config register block
`timescale 1ns/1ps
module bridge_sec_cfg_monitor
(
  input wire logic        I_REF_CLK,
  input wire logic        I_RESET_N,
  input wire logic        I_PSEL,
  input wire logic        I_PENABLE,
  input wire logic        I_PWRITE,
  input wire logic [11:0] I_PADDR,
  input wire logic [31:0] O_PRDATA,
  input wire logic        O_PREADY,
  input wire logic        O_PSLVERR,
  input wire logic        I_TLP_VALID,
  input wire logic        I_TLP_IS_IO,
  input wire logic        O_FWD_VALID,
  input wire logic        O_FWD_IO_HIT,
  input wire logic        O_FWD_MEM_HIT,
  input wire logic [7:0]  O_SUB_BUS
);
  default clocking cb @(posedge I_REF_CLK); endclocking
  default disable iff (!I_RESET_N);
  // Completed read of a mapped word; word index ignores the byte bits
  wire logic       rd_ok = O_PREADY && !O_PSLVERR && !I_PWRITE;
  wire logic [9:0] widx  = I_PADDR[11:2];
  // Completing write to the bus number word
  wire logic       bus_wr = I_PSEL && I_PENABLE && I_PWRITE && O_PREADY && widx == 10'h006;
  // Zero-wait slave: one ready pulse per setup
  property p_ready;
    I_PSEL && !I_PENABLE |=> O_PREADY ##1 !O_PREADY;
  endproperty
  a_ready: assert property (p_ready) else $error("ready not one cycle after setup");
  // Unmapped reads return zero together with ready
  property p_err;
    O_PSLVERR && !I_PWRITE |-> O_PREADY && O_PRDATA == 32'h0;
  endproperty
  a_err: assert property (p_err) else $error("error response malformed");
  property p_bus_word;
    rd_ok && widx == 10'h006 |-> O_PRDATA == {8'h00, O_SUB_BUS, 16'h0000};
  endproperty
  a_bus_word: assert property (p_bus_word) else $error("bus word image wrong");
  property p_io_word;
    rd_ok && widx == 10'h007 |-> O_PRDATA[3:0] == 4'h1 && O_PRDATA[11:8] == 4'h1
      && O_PRDATA[23:16] == 8'h00 && O_PRDATA[26:25] == 2'h0;
  endproperty
  a_io_word: assert property (p_io_word) else $error("io word fixed bits wrong");
  property p_mem_word;
    rd_ok && widx == 10'h008 |-> O_PRDATA[3:0] == 4'h0 && O_PRDATA[19:16] == 4'h0;
  endproperty
  a_mem_word: assert property (p_mem_word) else $error("mem word zero bits set");
  // Bus number moves only after a write to its word
  property p_sub_bus;
    !$stable(O_SUB_BUS) |-> $past(bus_wr);
  endproperty
  a_sub_bus: assert property (p_sub_bus) else $error("bus number changed unprompted");
  property p_fwd_valid;
    O_FWD_VALID == $past(I_TLP_VALID);
  endproperty
  a_fwd_valid: assert property (p_fwd_valid) else $error("decision not one cycle later");
  property p_io_hit;
    O_FWD_IO_HIT |-> $past(I_TLP_VALID && I_TLP_IS_IO) && !O_FWD_MEM_HIT;
  endproperty
  a_io_hit: assert property (p_io_hit) else $error("io hit without io offer");
  property p_mem_hit;
    O_FWD_MEM_HIT |-> $past(I_TLP_VALID && !I_TLP_IS_IO);
  endproperty
  a_mem_hit: assert property (p_mem_hit) else $error("mem hit without mem offer");
  c_err: cover property (O_PSLVERR);
  c_io: cover property (O_FWD_IO_HIT);
  c_mem: cover property (O_FWD_MEM_HIT);
endmodule

bind bridge_secondary_config_regs bridge_sec_cfg_monitor u_mon
(
  .I_REF_CLK(I_REF_CLK), .I_RESET_N(I_RESET_N), .I_PSEL(I_PSEL), .I_PENABLE(I_PENABLE),
  .I_PWRITE(I_PWRITE), .I_PADDR(I_PADDR), .O_PRDATA(O_PRDATA), .O_PREADY(O_PREADY),
  .O_PSLVERR(O_PSLVERR), .I_TLP_VALID(I_TLP_VALID), .I_TLP_IS_IO(I_TLP_IS_IO),
  .O_FWD_VALID(O_FWD_VALID), .O_FWD_IO_HIT(O_FWD_IO_HIT), .O_FWD_MEM_HIT(O_FWD_MEM_HIT),
  .O_SUB_BUS(O_SUB_BUS)
);

// ===== verif/sec_core_model.sv
// Secondary-side core model: error events and forwarded offers
`timescale 1ns/1ps
module sec_core_model
  import bridge_sec_pkg::*;
(
  input  wire logic i_clk,
  output err_evt_t  o_evt,
  output fwd_req_t  o_fwd
);
  // Quiet at time zero
  initial
  begin
    o_evt = '0;
    o_fwd = '0;
  end
  // One high cycle per call, since a held level counts as repeats
  task automatic pulse(input err_evt_t e);
    @(posedge i_clk);
    o_evt <= e;
    @(posedge i_clk);
    o_evt <= '0;
  endtask
  // One offer; afterwards the bus shows the inverse so stale data is never reused
  task automatic offer(input logic io, input logic [31:0] a);
    @(posedge i_clk);
    o_fwd <= '{valid: 1'b1, is_io: io, addr: a};
    @(posedge i_clk);
    o_fwd <= '{valid: 1'b0, is_io: ~io, addr: ~a};
  endtask
endmodule

// ===== verif/bridge_secondary_config_regs_tb_top.sv
// Self-checking bench for the secondary config register block
`timescale 1ns/1ps
module bridge_secondary_config_regs_tb_top
  import bridge_sec_pkg::*;
;
  logic        clk;      // Core clock
  logic        rst_n;    // Active-low reset
  apb_req_t    req;      // Master request
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  err_evt_t    evt;      // From the core model
  fwd_req_t    fwd;
  logic [15:0] up_b;     // Upper I/O base half
  logic [15:0] up_l;     // Upper I/O limit half
  logic        fwd_v;
  logic        io_hit;
  logic        mem_hit;
  logic [7:0]  sub_bus;
  int          error_cnt;
  int          compares;
  // Window probes: two just outside, two on the bounds, per window
  logic [31:0] tab_a [8] = '{32'h0001_2fff, 32'h0001_3000, 32'h0002_5fff, 32'h0002_6000,
                             32'h122f_ffff, 32'h1230_0000, 32'h124f_ffff, 32'h1250_0000};
  logic [7:0]  tab_h = 8'h66;

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  bridge_secondary_config_regs dut
  (
    .I_REF_CLK(clk), .I_RESET_N(rst_n), .I_PSEL(req.sel), .I_PENABLE(req.enable),
    .I_PWRITE(req.write), .I_PADDR(req.addr), .I_PWDATA(req.wdata), .I_PSTRB(req.strb),
    .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr),
    .I_PARITY_EVT(evt.parity), .I_CA_SENT_EVT(evt.ca_sent), .I_CA_RCVD_EVT(evt.ca_rcvd),
    .I_UR_RCVD_EVT(evt.ur_rcvd), .I_ERR_MSG_EVT(evt.err_msg), .I_POISON_EVT(evt.poison),
    .I_IO_BASE_UPPER(up_b), .I_IO_LIMIT_UPPER(up_l), .I_TLP_VALID(fwd.valid),
    .I_TLP_IS_IO(fwd.is_io), .I_TLP_ADDR(fwd.addr), .O_FWD_VALID(fwd_v),
    .O_FWD_IO_HIT(io_hit), .O_FWD_MEM_HIT(mem_hit), .O_SUB_BUS(sub_bus)
  );

  sec_core_model core
  (
    .i_clk(clk),
    .o_evt(evt),
    .o_fwd(fwd)
  );

  task automatic report_and_stop();
    $display("compares %0d error_cnt %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk_word(input string n, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e)
    begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic chk_bit(input string n, input logic e, input logic g);
    chk_word(n, {31'h0, e}, {31'h0, g});
  endtask

  // One APB transfer; released lines show inverted values
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic err);
    @(posedge clk);
    req <= '{sel: 1'b1, enable: 1'b0, write: w, addr: a, wdata: d, strb: 4'hf};
    @(posedge clk);
    req.enable <= 1'b1;
    // Wait as long as the slave needs; only the watchdog ends a hang
    do
    begin
      @(posedge clk);
    end
    while (pready !== 1'b1);
    chk_bit("pready", 1'b1, pready);
    r = prdata;
    err = pslverr;
    req <= '{sel: 1'b0, enable: 1'b0, write: ~w, addr: ~a, wdata: ~d, strb: 4'h0};
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic ee);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
    chk_bit("pslverr", ee, e);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] x, input logic ee);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0, r, e);
    chk_bit("pslverr", ee, e);
    chk_word("prdata", x, r);
  endtask

  // Offer one transaction and check the decision a cycle later
  task automatic fwd_chk(input logic io, input logic [31:0] a, input logic h);
    core.offer(io, a);
    #1;
    chk_bit("fwd_valid", 1'b1, fwd_v);
    chk_bit("io_hit", io & h, io_hit);
    chk_bit("mem_hit", !io & h, mem_hit);
  endtask

  // Watchdog: the sequence needs well under 2000 cycles
  initial
  begin
    #50us;
    error_cnt++;
    report_and_stop();
  end

  initial
  begin
    rst_n = 1'b0;
    req = '0;
    up_b = 16'h0;
    up_l = 16'h0;
    error_cnt = 0;
    compares = 0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    rd(12'h018, 32'h0000_0000, 1'b0);
    rd(12'h01c, 32'h0000_0101, 1'b0);
    rd(12'h020, 32'h0000_0000, 1'b0);
    rd(12'h040, 32'h0000_0000, 1'b0);
    // All-ones writes leave only the writable fields set
    wr(12'h018, 32'hffff_ffff, 1'b0);
    rd(12'h018, 32'h00ff_0000, 1'b0);
    chk_word("sub_bus", 32'h0000_00ff, {24'h0, sub_bus});
    wr(12'h01c, 32'hffff_ffff, 1'b0);
    rd(12'h01c, 32'h0000_f1f1, 1'b0);
    wr(12'h020, 32'hffff_ffff, 1'b0);
    rd(12'h020, 32'hfff0_fff0, 1'b0);
    // Unmapped word is refused
    wr(12'h100, 32'hffff_ffff, 1'b1);
    rd(12'h100, 32'h0000_0000, 1'b1);
    // Gated flags stay clear while their enables are off
    core.pulse('1);
    rd(12'h01c, 32'hb800_f1f1, 1'b0);
    wr(12'h040, 32'h0000_0003, 1'b0);
    rd(12'h040, 32'h0000_0003, 1'b0);
    core.pulse('{parity: 1'b1, err_msg: 1'b1, default: 1'b0});
    rd(12'h01c, 32'hf900_f1f1, 1'b0);
    // Zeros keep flags; ones clear only the clearable ones
    wr(12'h01c, 32'h0000_f0f0, 1'b0);
    rd(12'h01c, 32'hf900_f1f1, 1'b0);
    wr(12'h01c, 32'hffff_ffff, 1'b0);
    rd(12'h01c, 32'h3800_f1f1, 1'b0);
    // Windows: I/O 0001_3000..0002_5fff, memory 1230_0000..124f_ffff
    up_b <= 16'h0001;
    up_l <= 16'h0002;
    wr(12'h01c, 32'h0000_5030, 1'b0);
    wr(12'h020, 32'h1240_1230, 1'b0);
    for (int i = 0; i < 8; i++)
      fwd_chk(i < 4, tab_a[i], tab_h[i]);
    fwd_chk(1'b1, 32'h1230_0000, 1'b0);
    fwd_chk(1'b0, 32'h0001_3000, 1'b0);
    // Upper halves move the I/O window
    @(posedge clk);
    up_b <= 16'h0002;
    fwd_chk(1'b1, 32'h0002_3000, 1'b1);
    fwd_chk(1'b1, 32'h0001_3000, 1'b0);
    // Reset in mid-run clears the sticky flags
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    rd(12'h01c, 32'h0000_0101, 1'b0);
    rd(12'h020, 32'h0000_0000, 1'b0);
    chk_word("sub_bus", 32'h0000_0000, {24'h0, sub_bus});
    report_and_stop();
  end
endmodule
